//--- verilog/svm_pkg.sv
// constants and state type for the supply voltage monitor sequencer
// Overview of operation
// R1: convert the supply-sense input once every 100 us while monitoring runs.
// R2: start conversions only on the interval timer tick; otherwise wait idle.
// R3: one conversion per trigger, then back to waiting for the next tick.
// R4: convert one fixed channel taken from a channel-select setting, no scanning.
// R5: raise the done event only when the result is at or below 0x5F.
// R6: on each done event, log the result present at that moment into flash; an event that arrives while the previous write awaits its ack is not logged.
// R7: after a done event, blink the lamp output with a 0.5 s period.
// R8: block select 0..3 maps to 1 KiB blocks from 0xF1000; stay inside it.
// R9: each log entry is a single byte, never above 0xFF.
// R10: converter and timers all run from the single system clock.
// R11: results are 8-bit, so threshold and logged bytes are 8-bit.
// R12: pick the internal reference only while stopped; enable after 5 us settling.
// R13: advance the log address one byte per write; stop at the block's end.
// R14: the done event is a one-cycle pulse per qualifying conversion.
package svm_pkg;
   localparam int CLK_MHZ = 100;
   localparam int SAMPLE_US = 100;
   localparam int SETTLE_US = 5;
   localparam int BLINK_PERIOD_MS = 500;
   localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
   localparam int SETTLE_CYC = (SETTLE_US * CLK_MHZ < 1) ? 1 : SETTLE_US * CLK_MHZ;
   localparam int BLINK_HALF_CYC = BLINK_PERIOD_MS * 1000 * CLK_MHZ / 2;
   localparam logic [7:0] LOW_THRESHOLD = 8'h5F;
   localparam logic [19:0] FLASH_BASE = 20'hF_1000;
   localparam logic [19:0] BLOCK_SIZE = 20'h0_0400;
   localparam logic [9:0] BLOCK_LAST = 10'h3FF;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_MASK = 8'h08;
   localparam logic [7:0] OFF_RESULT = 8'h0C;
   localparam logic [7:0] OFF_LOGADDR = 8'h10;
   localparam int CTRL_EN = 0;
   localparam int CTRL_BLK_LSB = 1;
   localparam int CTRL_CH_LSB = 4;
   localparam int ST_LOW = 0;
   localparam int ST_FULL = 1;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {SVM_OFF, SVM_SETTLE, SVM_WAIT, SVM_CONV} svm_state_t;
endpackage

//--- verilog/svm_monitor.sv
// supply voltage monitor sequencer with axi4-lite registers
`timescale 1ns/1ps
module svm_monitor
   import svm_pkg::*;
#(
   parameter int SAMPLE_CYCLES = SAMPLE_CYC,
   parameter int BLINK_HALF_CYCLES = BLINK_HALF_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic ref_select_high,
   output logic ref_select_low,
   output logic comparator_enable,
   output logic conversion_run,
   output logic conv_start,
   output logic [2:0] adc_channel,
   input wire logic adc_done,
   input wire logic [7:0] adc_result,
   output logic conversion_done_event,
   output logic flash_wr_req,
   output logic [19:0] flash_wr_addr,
   output logic [7:0] flash_wr_data,
   input wire logic flash_wr_ack,
   output logic indicator_timer_output,
   output logic irq
);
   // ---------------- bus slave ----------------
   logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg, rdata_reg;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [6:0] ctrl_reg;
   logic [1:0] status_reg, mask_reg;
   logic [7:0] result_reg;
   logic [9:0] ptr_reg;
   logic full_reg, irq_reg;

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire wr_ctrl = do_write && wstrb_reg[0] && awaddr_reg == OFF_CTRL;
   wire wr_status = do_write && wstrb_reg[0] && awaddr_reg == OFF_STATUS;
   wire wr_mask = do_write && wstrb_reg[0] && awaddr_reg == OFF_MASK;
   wire wr_mapped = awaddr_reg == OFF_CTRL || awaddr_reg == OFF_STATUS
                    || awaddr_reg == OFF_MASK || awaddr_reg == OFF_RESULT
                    || awaddr_reg == OFF_LOGADDR;
   wire rd_mapped = s_axi_araddr == OFF_CTRL || s_axi_araddr == OFF_STATUS
                    || s_axi_araddr == OFF_MASK || s_axi_araddr == OFF_RESULT
                    || s_axi_araddr == OFF_LOGADDR;
   wire [31:0] rd_mux = (s_axi_araddr == OFF_CTRL) ? {25'h0, ctrl_reg} :
                        (s_axi_araddr == OFF_STATUS) ? {30'h0, status_reg} :
                        (s_axi_araddr == OFF_MASK) ? {30'h0, mask_reg} :
                        (s_axi_araddr == OFF_RESULT) ? {24'h0, result_reg} :
                        (s_axi_araddr == OFF_LOGADDR) ? {12'h0, flash_wr_addr} :
                        32'h0000_0000;

   assign s_axi_awready = !aw_hold_reg;
   assign s_axi_wready = !w_hold_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_mux;
         rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ---------------- sequencer ----------------
   svm_state_t state_reg, state_next;
   logic [31:0] smp_cnt_reg, settle_cnt_reg, blink_cnt_reg;
   logic conv_start_reg, event_reg, req_reg, blink_en_reg, lamp_reg;
   logic [7:0] wr_data_reg;
   logic ref_linger_reg; // reference drops one cycle after the comparator

   wire enable = ctrl_reg[CTRL_EN];
   wire [1:0] blk_sel = ctrl_reg[CTRL_BLK_LSB +: 2];
   wire tick = enable && smp_cnt_reg == 32'(SAMPLE_CYCLES - 1); // R1
   wire settled = settle_cnt_reg == 32'(SETTLE_CYC - 1);
   wire conv_end = state_reg == SVM_CONV && adc_done;
   wire low_hit = conv_end && adc_result <= LOW_THRESHOLD; // R5 R11
   wire log_take = event_reg && !full_reg && !req_reg;
   wire log_done = req_reg && flash_wr_ack;
   wire [19:0] blk_base = FLASH_BASE + 20'(blk_sel) * BLOCK_SIZE; // R8

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SVM_OFF: if (enable) state_next = SVM_SETTLE; // R12
         SVM_SETTLE: if (!enable) state_next = SVM_OFF; else if (settled) state_next = SVM_WAIT;
         SVM_WAIT: if (!enable) state_next = SVM_OFF; else if (tick) state_next = SVM_CONV; // R2
         SVM_CONV: if (adc_done) state_next = enable ? SVM_WAIT : SVM_OFF; // R3
         default: state_next = SVM_OFF;
      endcase
   end

   assign ref_select_high = state_reg != SVM_OFF || ref_linger_reg; // R12
   assign ref_select_low = 1'b0;
   assign comparator_enable = state_reg == SVM_WAIT || state_reg == SVM_CONV;
   assign conversion_run = state_reg == SVM_CONV;
   assign conv_start = conv_start_reg;
   assign adc_channel = ctrl_reg[CTRL_CH_LSB +: 3]; // R4
   assign conversion_done_event = event_reg;
   assign flash_wr_req = req_reg;
   assign flash_wr_addr = blk_base | {10'h000, ptr_reg};
   assign flash_wr_data = wr_data_reg;
   assign indicator_timer_output = lamp_reg;
   assign irq = irq_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= SVM_OFF;
         smp_cnt_reg <= 32'h0000_0000;
         settle_cnt_reg <= 32'h0000_0000;
         conv_start_reg <= 1'b0;
         event_reg <= 1'b0;
         result_reg <= 8'h00;
         ref_linger_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         // period counter runs from enable, so ticks stay 100 us apart
         smp_cnt_reg <= (!enable || tick) ? 32'h0000_0000 : smp_cnt_reg + 32'h0000_0001; // R10
         settle_cnt_reg <= (state_reg == SVM_SETTLE) ? settle_cnt_reg + 32'h0000_0001
                           : 32'h0000_0000; // R12
         conv_start_reg <= state_reg == SVM_WAIT && state_next == SVM_CONV; // R2
         event_reg <= low_hit; // R14
         if (conv_end) result_reg <= adc_result;
         ref_linger_reg <= comparator_enable; // R12
      end
   end

   // ---------------- flash log ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_reg <= 1'b0;
         wr_data_reg <= 8'h00;
         ptr_reg <= 10'h000;
         full_reg <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            // a new block choice restarts logging at that block's base
            ptr_reg <= 10'h000;
            full_reg <= 1'b0;
         end else if (log_done) begin
            if (ptr_reg == BLOCK_LAST) full_reg <= 1'b1; // R13
            else ptr_reg <= ptr_reg + 10'h001; // R13
         end
         if (log_take) begin
            req_reg <= 1'b1;
            wr_data_reg <= result_reg; // R6 R9
         end else if (log_done) begin
            req_reg <= 1'b0;
         end
      end
   end

   // ---------------- lamp blink ----------------
   wire half_done = blink_cnt_reg == 32'(BLINK_HALF_CYCLES - 1);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blink_en_reg <= 1'b0;
         blink_cnt_reg <= 32'h0000_0000;
         lamp_reg <= 1'b0;
      end else begin
         if (event_reg) blink_en_reg <= 1'b1; // R7
         else if (!enable) blink_en_reg <= 1'b0;
         if (!blink_en_reg || half_done) blink_cnt_reg <= 32'h0000_0000;
         else blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
         if (!blink_en_reg) lamp_reg <= 1'b0;
         else if (half_done) lamp_reg <= !lamp_reg; // R7
      end
   end

   // ---------------- registers and interrupt ----------------
   wire [1:0] sts_set = {log_done && ptr_reg == BLOCK_LAST, event_reg};
   wire [1:0] sts_clr = wr_status ? wdata_reg[1:0] : 2'b00;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= 7'h00;
         mask_reg <= 2'b00;
         status_reg <= 2'b00;
         irq_reg <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl_reg <= wdata_reg[6:0];
         if (wr_mask) mask_reg <= wdata_reg[1:0];
         // set beats a same-cycle write-one clear
         status_reg <= (status_reg & ~sts_clr) | sts_set;
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   // ---------------- checks ----------------
   a_event_low_only: assert property (@(posedge aclk) disable iff (!aresetn) // R5
      conversion_done_event |-> $past(adc_done) && $past(adc_result) <= LOW_THRESHOLD
         && $past(conversion_run))
      else $error("done event without low result");
   a_event_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn) // R14
      conversion_done_event |=> !conversion_done_event)
      else $error("done event longer than one cycle");
   a_start_after_tick: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      conv_start |-> $past(tick) && $past(state_reg == SVM_WAIT) && conversion_run)
      else $error("conversion started without tick");
   a_one_conv_trigger: assert property (@(posedge aclk) disable iff (!aresetn) // R3
      conversion_run && adc_done |=> !conversion_run)
      else $error("conversion kept running after result");
   a_ref_settle_time: assert property (@(posedge aclk) disable iff (!aresetn) // R12
      $rose(comparator_enable) |-> $past(settle_cnt_reg) == 32'(SETTLE_CYC - 1)
         && ref_select_high)
      else $error("comparator enabled before settling");
   a_ref_change_stopped: assert property (@(posedge aclk) disable iff (!aresetn) // R12
      $changed(ref_select_high) |-> !$past(comparator_enable) && !$past(conversion_run))
      else $error("reference changed while converting");
   a_log_follows_event: assert property (@(posedge aclk) disable iff (!aresetn) // R6
      conversion_done_event && !full_reg && !flash_wr_req && !wr_ctrl
         |=> flash_wr_req && flash_wr_data == result_reg)
      else $error("event not logged");
   a_addr_in_block: assert property (@(posedge aclk) disable iff (!aresetn) // R8
      flash_wr_req |-> flash_wr_addr >= blk_base && flash_wr_addr <= blk_base + 20'h0_03FF)
      else $error("log address outside block");
   a_log_advance: assert property (@(posedge aclk) disable iff (!aresetn) // R13
      flash_wr_req && flash_wr_ack && !wr_ctrl && ptr_reg != BLOCK_LAST
         |=> ptr_reg == $past(ptr_reg) + 10'h001 && !full_reg)
      else $error("log address did not advance");
   a_lamp_half_period: assert property (@(posedge aclk) disable iff (!aresetn) // R7
      $changed(indicator_timer_output) && $past(blink_en_reg)
         |-> $past(blink_cnt_reg) == 32'(BLINK_HALF_CYCLES - 1))
      else $error("lamp toggled off schedule");

   // guards for the start pulse, the result, the reference, the log port, the lamp and the interrupt
   a_start_one_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      conv_start |=> !conv_start)
      else $error("start pulse longer than one cycle");
   a_run_needs_start: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      $rose(conversion_run) |-> conv_start)
      else $error("conversion ran without start pulse");
   a_wait_stays_idle: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      state_reg == SVM_WAIT && !tick |=> !conversion_run)
      else $error("conversion began without tick");
   a_result_capture: assert property (@(posedge aclk) disable iff (!aresetn) // R11
      conversion_run && adc_done |=> result_reg == $past(adc_result))
      else $error("result byte not captured");
   a_event_result_low: assert property (@(posedge aclk) disable iff (!aresetn) // R5
      conversion_done_event |-> result_reg <= LOW_THRESHOLD)
      else $error("event with result above threshold");
   a_comp_needs_ref: assert property (@(posedge aclk) disable iff (!aresetn) // R12
      comparator_enable |-> ref_select_high)
      else $error("comparator on without reference");
   a_settle_comp_off: assert property (@(posedge aclk) disable iff (!aresetn) // R12
      state_reg == SVM_SETTLE |-> ref_select_high && !comparator_enable)
      else $error("comparator on during settling");
   a_req_held: assert property (@(posedge aclk) disable iff (!aresetn) // R6
      flash_wr_req && !flash_wr_ack && !wr_ctrl
         |=> flash_wr_req && $stable(flash_wr_addr) && $stable(flash_wr_data))
      else $error("log request changed before ack");
   a_req_drop_ack: assert property (@(posedge aclk) disable iff (!aresetn) // R13
      flash_wr_req && flash_wr_ack |=> !flash_wr_req)
      else $error("log request held after ack");
   a_ptr_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R13
      !(flash_wr_req && flash_wr_ack) && !wr_ctrl |=> $stable(ptr_reg))
      else $error("log address moved without a write");
   a_full_at_last: assert property (@(posedge aclk) disable iff (!aresetn) // R13
      flash_wr_req && flash_wr_ack && ptr_reg == BLOCK_LAST && !wr_ctrl
         |=> full_reg && status_reg[ST_FULL])
      else $error("block end not flagged");
   a_full_no_log: assert property (@(posedge aclk) disable iff (!aresetn) // R13
      full_reg && !flash_wr_req && !wr_ctrl |=> !flash_wr_req)
      else $error("logging past block end");
   a_blink_after_event: assert property (@(posedge aclk) disable iff (!aresetn) // R7
      conversion_done_event |=> blink_en_reg)
      else $error("blinking not started by event");
   a_lamp_off_idle: assert property (@(posedge aclk) disable iff (!aresetn) // R7
      !blink_en_reg |=> !indicator_timer_output)
      else $error("lamp lit while not blinking");
   a_status_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
      event_reg |=> status_reg[ST_LOW])
      else $error("event status bit not set");
   a_irq_follows_status: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |-> irq == $past(|(status_reg & mask_reg)))
      else $error("interrupt does not follow status");

endmodule

//--- verification/svm_far_model.sv
// far-side model: sense converter front end and data flash write port
`timescale 1ns/1ps
module svm_far_model #(
   parameter int CONV_CYC = 4,
   parameter logic [2:0] SENSE_CH = 3'h5
) (
   input wire logic aclk,
   input wire logic conv_start,
   input wire logic [2:0] adc_channel,
   input wire logic [7:0] level,
   input wire logic [3:0] ack_wait,
   input wire logic flash_wr_req,
   input wire logic [19:0] flash_wr_addr,
   input wire logic [7:0] flash_wr_data,
   output logic adc_done,
   output logic [7:0] adc_result,
   output logic flash_wr_ack
);
   int conv_cnt = 0;
   int ack_cnt = 0;
   logic [19:0] log_addr[$];
   logic [7:0] log_data[$];
   initial begin
      adc_done = 1'b0;
      adc_result = 8'h00;
      flash_wr_ack = 1'b0;
   end
   always @(posedge aclk) begin
      adc_done <= 1'b0;
      flash_wr_ack <= 1'b0;
      // result is only valid with adc_done; keep it moving otherwise
      adc_result <= ~adc_result;
      if (conv_start) begin
         conv_cnt <= CONV_CYC;
      end else if (conv_cnt == 1) begin
         adc_done <= 1'b1;
         // a wrong channel reads full scale, so a scanning design is caught
         adc_result <= (adc_channel == SENSE_CH) ? level : 8'hFF;
         conv_cnt <= 0;
      end else if (conv_cnt > 1) begin
         conv_cnt <= conv_cnt - 1;
      end
      if (flash_wr_req && !flash_wr_ack) begin
         if (ack_cnt >= int'(ack_wait)) begin
            flash_wr_ack <= 1'b1;
            ack_cnt <= 0;
            log_addr.push_back(flash_wr_addr);
            log_data.push_back(flash_wr_data);
         end else begin
            ack_cnt <= ack_cnt + 1;
         end
      end
   end
endmodule

//--- verification/svm_monitor_tb_top.sv
// self-checking bench for the supply voltage monitor sequencer
`timescale 1ns/1ps
module svm_monitor_tb_top;
   import svm_pkg::*;
   localparam int SAMP = 50;
   localparam int HALF = 20;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr, level;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb, ack_wait;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
   logic ref_select_high, ref_select_low, comparator_enable, conversion_run, conv_start;
   logic [2:0] adc_channel;
   logic adc_done, conversion_done_event, flash_wr_req, flash_wr_ack, indicator_timer_output, irq;
   logic [7:0] adc_result, flash_wr_data;
   logic [19:0] flash_wr_addr;
   int error_cnt = 0;
   int n_tests = 0;
   int n;
   svm_monitor #(.SAMPLE_CYCLES(SAMP), .BLINK_HALF_CYCLES(HALF)) u_dut (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_select_high,
      .ref_select_low, .comparator_enable, .conversion_run, .conv_start, .adc_channel, .adc_done,
      .adc_result, .conversion_done_event, .flash_wr_req, .flash_wr_addr, .flash_wr_data,
      .flash_wr_ack, .indicator_timer_output, .irq);
   svm_far_model u_far (.aclk, .conv_start, .adc_channel, .level, .ack_wait, .flash_wr_req,
      .flash_wr_addr, .flash_wr_data, .adc_done, .adc_result, .flash_wr_ack);
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic fail(input string m);
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask
   task automatic chk1(input logic got, input logic exp, input string m);
      n_tests++;
      if (got !== exp) fail(m);
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) fail(m);
   endtask
   // caller stands just after a rising edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      br = s_axi_bresp;
      if (i == 50) begin
         fail("write hang");
         stop_test();
      end
   endtask
   task automatic axi_rd(input logic [7:0] a);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      if (i == 50) begin
         fail("read hang");
         stop_test();
      end
   endtask
   // sel 0 start, 1 event, 2 comparator on, 3 lamp on, 4 lamp off
   task automatic wait_on(input int sel, input int lim);
      for (n = 0; n < lim; n++) begin
         @(posedge aclk);
         case (sel)
            0: if (conv_start === 1'b1) return;
            1: if (conversion_done_event === 1'b1) return;
            2: if (comparator_enable === 1'b1) return;
            3: if (indicator_timer_output === 1'b1) return;
            default: if (indicator_timer_output === 1'b0) return;
         endcase
      end
      fail("wait hang");
      stop_test();
   endtask
   task automatic wait_log(input int k);
      // poll between edges so the model's push cannot race the check
      for (int i = 0; i < 40 && u_far.log_data.size() < k; i++) @(negedge aclk);
      @(posedge aclk);
      chk1(u_far.log_data.size() == k, 1'b1, "log count");
   endtask
   task automatic t_reset();
      chk1(ref_select_high, 1'b0, "ref off in reset");
      chk1(ref_select_low, 1'b0, "ref low");
      chk1(s_axi_awready, 1'b1, "awready");
      chk1(irq, 1'b0, "irq");
      axi_rd(OFF_CTRL);
      chk32(rd, 32'h0000_0000, "ctrl reset");
   endtask
   task automatic t_settle();
      axi_wr(OFF_CTRL, 32'h0000_0057);
      @(posedge aclk);
      chk1(ref_select_high, 1'b1, "ref select");
      chk1(comparator_enable, 1'b0, "early enable");
      wait_on(2, 600);
      chk1(n == SETTLE_CYC - 1, 1'b1, "settle time");
   endtask
   task automatic t_high();
      wait_on(0, 200);
      chk32(32'(adc_channel), 32'h0000_0005, "channel");
      wait_on(0, 200);
      chk1(n == SAMP - 1, 1'b1, "sample period");
      chk1(conversion_run, 1'b1, "run with start");
      axi_rd(OFF_RESULT);
      chk32(rd, 32'h0000_0060, "result");
      repeat (5) @(posedge aclk);
      chk1(conversion_run, 1'b0, "one shot");
      axi_rd(OFF_STATUS);
      chk32(rd, 32'h0000_0000, "no event above threshold");
   endtask
   task automatic t_log();
      axi_wr(OFF_MASK, 32'h0000_0001);
      chk32({30'h0, br}, {30'h0, RESP_OKAY}, "mapped write resp");
      level <= LOW_THRESHOLD;
      wait_on(1, 200);
      @(posedge aclk);
      chk1(conversion_done_event, 1'b0, "event width");
      level <= 8'h60;
      wait_log(1);
      chk32(32'(u_far.log_addr[0]), 32'h000F_1C00, "block base");
      chk32(32'(u_far.log_data[0]), 32'h0000_005F, "logged byte");
      chk1(irq, 1'b1, "irq raised");
      axi_wr(OFF_STATUS, 32'h0000_0001);
      @(posedge aclk);
      chk1(irq, 1'b0, "irq cleared");
      ack_wait <= 4'h3;
      level <= 8'h00;
      wait_on(1, 200);
      level <= 8'h60;
      wait_log(2);
      chk32(32'(u_far.log_addr[1]), 32'h000F_1C01, "next address");
      chk32(32'(u_far.log_data[1]), 32'h0000_0000, "zero byte");
      axi_rd(OFF_LOGADDR);
      chk32(rd, 32'h000F_1C02, "log pointer");
      chk1(irq, 1'b1, "irq again");
      axi_wr(OFF_MASK, 32'h0000_0000);
      repeat (2) @(posedge aclk);
      chk1(irq, 1'b0, "irq masked");
   endtask
   task automatic t_lamp();
      wait_on(4, 100);
      wait_on(3, 100);
      wait_on(4, 100);
      chk1(n == HALF - 1, 1'b1, "blink half period");
      axi_rd(8'h20);
      chk32({30'h0, rr}, {30'h0, RESP_SLVERR}, "unmapped resp");
      chk32(rd, 32'h0000_0000, "unmapped data");
      axi_wr(8'h20, 32'hFFFF_FFFF);
      chk32({30'h0, br}, {30'h0, RESP_SLVERR}, "unmapped write resp");
      s_axi_wstrb <= 4'h0;
      axi_wr(OFF_CTRL, 32'h0000_0000);
      s_axi_wstrb <= 4'hF;
      axi_rd(OFF_CTRL);
      chk32(rd, 32'h0000_0057, "strobe off keeps ctrl");
      axi_wr(OFF_CTRL, 32'h0000_0000);
      repeat (12) @(posedge aclk);
      chk1(indicator_timer_output, 1'b0, "lamp off when disabled");
      chk1(comparator_enable, 1'b0, "comparator off when disabled");
      chk1(ref_select_high, 1'b0, "ref off when disabled");
      axi_rd(OFF_LOGADDR);
      chk32(rd, 32'h000F_1000, "block zero base");
   endtask
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      level = 8'h60;
      ack_wait = 4'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_settle();
      t_high();
      t_log();
      t_lamp();
      stop_test();
   end
endmodule
